// file: design/sysctl_pkg.sv
// Constants for the stack, stop-guard and system mode register bank
package sysctl_pkg;
    // Register offsets in the register-addressed space
    localparam logic [7:0] OFF_STACK_POINTER_HIGH  = 8'hd8;
    localparam logic [7:0] OFF_STACK_POINTER_LOW   = 8'hd9;
    localparam logic [7:0] OFF_STOP_GUARD_KEY      = 8'hfb;
    localparam logic [7:0] OFF_SYSTEM_MODE_CONTROL = 8'hde;
    // Stop-guard key and reset value
    localparam logic [7:0] STOP_KEY                = 8'ha5;
    localparam logic [7:0] STOP_GUARD_RESET        = 8'h00;
    // System mode field positions
    localparam int         MODE_GIE_BIT            = 0;
    localparam int         MODE_FIE_BIT            = 1;
    localparam int         MODE_LVL_LSB            = 2;
    localparam int         MODE_LVL_MSB            = 4;
    localparam int         MODE_B7_BIT             = 7;
    localparam logic [2:0] LEVEL_FIELD_RESET       = 3'h0;
    // Length of the stop-failure reset pulse in cycles
    localparam logic [3:0] STOP_RESET_CYCLES       = 4'h4;
endpackage : sysctl_pkg

// file: design/stop_guard.sv
// Stop-guard key register and stop/reset decision
`timescale 1ns/1ps
module stop_guard (
    input  wire logic       sys_clk,       // Core clock
    input  wire logic       reset,         // Async reset, active high
    input  wire logic       clk_en,        // Freezes state when low
    input  wire logic       wr_en,         // Write strobe to this register
    input  wire logic [7:0] wr_data,       // Write data
    input  wire logic       stop_exec,     // Stop instruction pulse
    output logic      [7:0] key_value,     // Current register contents
    output logic            stop_enter,    // Stop mode granted pulse
    output logic            stop_reset     // Reset request level
);
    logic [7:0] key_ff, nxt_key;
    logic       enter_ff, nxt_enter;
    logic [3:0] rst_cnt_ff, nxt_rst_cnt;

    // Next-state of key, stop grant and failure reset
    always_comb begin
        nxt_key     = key_ff;
        nxt_enter   = 1'h0;
        nxt_rst_cnt = rst_cnt_ff;
        if (rst_cnt_ff != 4'h0) begin
            nxt_rst_cnt = rst_cnt_ff - 4'h1;
        end
        if (wr_en) begin
            nxt_key = wr_data;
        end
        if (stop_exec) begin
            if (key_ff == sysctl_pkg::STOP_KEY) begin
                nxt_enter = 1'h1;
            end else begin
                nxt_rst_cnt = sysctl_pkg::STOP_RESET_CYCLES;
            end
        end
    end

    // State registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            key_ff     <= sysctl_pkg::STOP_GUARD_RESET;
            enter_ff   <= 1'h0;
            rst_cnt_ff <= 4'h0;
        end else if (clk_en) begin
            key_ff     <= nxt_key;
            enter_ff   <= nxt_enter;
            rst_cnt_ff <= nxt_rst_cnt;
        end
    end

    assign key_value  = key_ff;
    assign stop_enter = enter_ff;
    assign stop_reset = (rst_cnt_ff != 4'h0);
endmodule : stop_guard

// file: design/stack_stop_sysmode_regs.sv
// Stack pointer, stop-guard and system mode register bank
// Behaviour
// - High stack pointer byte, read/write at d8
// - Low stack pointer byte at d9, forms pointer
// - Stack pointer bytes untouched by reset
// - Stop honoured only with key pattern stored
// - Stop with wrong key causes reset instead
// - Registers reachable by register addressing only
// - Mode bits 4..2 pick fast level, undefined reset (reset loads 0 here)
// - Mode bit 1 enables fast interrupts, resets 0
// - Mode bit 0 gates all interrupts, resets 0
// - Only the chosen level is fast
`timescale 1ns/1ps
module stack_stop_sysmode_regs (
    input  wire logic        sys_clk,       // Core clock, 250 MHz
    input  wire logic        reset,         // Async reset, active high
    input  wire logic        clk_en,        // Freezes state when low
    input  wire logic        reg_mode,      // Access uses register addressing
    input  wire logic        reg_wr,        // Register write strobe
    input  wire logic        reg_rd,        // Register read strobe
    input  wire logic [7:0]  reg_addr,      // Register offset
    input  wire logic [7:0]  reg_wdata,     // Write data
    output logic      [7:0]  reg_rdata,     // Registered read data
    output logic             reg_hit,       // Offset belongs to this bank
    input  wire logic        sp_load,       // Core loads stack pointer
    input  wire logic [15:0] sp_load_val,   // Value from push/pop logic
    input  wire logic        ei_exec,       // Enable-interrupt instruction
    input  wire logic        di_exec,       // Disable-interrupt instruction
    input  wire logic        stop_exec,     // Stop instruction pulse
    output logic      [15:0] stack_pointer, // Full stack pointer
    output logic             stop_enter,    // Stop mode granted pulse
    output logic             stop_reset,    // Reset request on bad stop
    output logic             global_int_en, // Interrupt gate
    output logic             fast_int_en,   // Fast processing enabled
    output logic      [2:0]  fast_level,    // Chosen fast level
    output logic      [7:0]  fast_level_sel // One-hot fast level
);
    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Register addressing and a matching offset select one register
    function automatic logic offset_hit(input logic       mode,
                                        input logic [7:0] addr,
                                        input logic [7:0] offset);
        offset_hit = mode && (addr == offset);
    endfunction : offset_hit

    // One-hot level code, all zero while fast processing is off
    function automatic logic [7:0] level_onehot(input logic       enable,
                                                input logic [2:0] level);
        level_onehot = 8'h00;
        if (enable) begin
            level_onehot[level] = 1'h1;
        end
    endfunction : level_onehot

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic sel_sph, sel_spl, sel_key, sel_mode;
    logic wr_ok;

    // Decode only under register addressing
    always_comb begin
        sel_sph  = offset_hit(reg_mode, reg_addr,
                              sysctl_pkg::OFF_STACK_POINTER_HIGH);
        sel_spl  = offset_hit(reg_mode, reg_addr,
                              sysctl_pkg::OFF_STACK_POINTER_LOW);
        sel_key  = offset_hit(reg_mode, reg_addr,
                              sysctl_pkg::OFF_STOP_GUARD_KEY);
        sel_mode = offset_hit(reg_mode, reg_addr,
                              sysctl_pkg::OFF_SYSTEM_MODE_CONTROL);
        wr_ok    = reg_wr;
    end

    // Handshake output, combinational so the core sees it at once
    assign reg_hit = sel_sph || sel_spl || sel_key || sel_mode;

    // ****************************************************************
    // Stack pointer
    // ****************************************************************
    logic [15:0] sp_ff, nxt_sp;

    // Byte writes or whole-pointer load from core
    always_comb begin
        nxt_sp = sp_ff;
        if (sp_load) begin
            nxt_sp = sp_load_val;
        end
        if (wr_ok && sel_sph) begin
            nxt_sp[15:8] = reg_wdata;
        end
        if (wr_ok && sel_spl) begin
            nxt_sp[7:0] = reg_wdata;
        end
    end

    // No reset term: contents stay undefined until written
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            sp_ff <= nxt_sp;
        end
    end
    assign stack_pointer = sp_ff;

    // ****************************************************************
    // System mode control
    // ****************************************************************
    logic [2:0] lvl_ff, nxt_lvl;
    logic       fie_ff, nxt_fie;
    logic       gie_ff, nxt_gie;
    logic       b7_ff, nxt_b7;

    // Field writes; gate also moved by instructions
    always_comb begin
        nxt_lvl = lvl_ff;
        nxt_fie = fie_ff;
        nxt_gie = gie_ff;
        nxt_b7  = b7_ff;
        if (wr_ok && sel_mode) begin
            nxt_lvl = reg_wdata[sysctl_pkg::MODE_LVL_MSB:
                                sysctl_pkg::MODE_LVL_LSB];
            nxt_fie = reg_wdata[sysctl_pkg::MODE_FIE_BIT];
            nxt_gie = reg_wdata[sysctl_pkg::MODE_GIE_BIT];
            nxt_b7  = reg_wdata[sysctl_pkg::MODE_B7_BIT];
        end
        if (di_exec) begin
            nxt_gie = 1'h0;
        end
        // Instruction wins over a write in the same cycle
        if (ei_exec) begin
            nxt_gie = 1'h1;
        end
    end

    // Level field has no defined reset; give it a known code
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            lvl_ff <= sysctl_pkg::LEVEL_FIELD_RESET;
            fie_ff <= 1'h0;
            gie_ff <= 1'h0;
            b7_ff  <= 1'h0;
        end else if (clk_en) begin
            lvl_ff <= nxt_lvl;
            fie_ff <= nxt_fie;
            gie_ff <= nxt_gie;
            b7_ff  <= nxt_b7;
        end
    end

    // Mode outputs straight from their flops
    assign global_int_en = gie_ff;
    assign fast_int_en   = fie_ff;
    assign fast_level    = lvl_ff;

    logic [7:0] sel_ff, nxt_sel;

    // Exactly one level marked fast, only when enabled
    always_comb begin
        nxt_sel = level_onehot(nxt_fie, nxt_lvl);
    end

    // Registered beside the mode flops, so it never lags them
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sel_ff <= 8'h00;
        end else if (clk_en) begin
            sel_ff <= nxt_sel;
        end
    end
    assign fast_level_sel = sel_ff;

    // ****************************************************************
    // Stop guard
    // ****************************************************************
    logic [7:0] key_value;

    // Key register and stop decision kept in their own module
    stop_guard u_stop_guard (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .clk_en     (clk_en),
        .wr_en      (wr_ok && sel_key),
        .wr_data    (reg_wdata),
        .stop_exec  (stop_exec),
        .key_value  (key_value),
        .stop_enter (stop_enter),
        .stop_reset (stop_reset)
    );

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [7:0] rdata_ff, nxt_rdata;

    // Mux selected register; bits 6..5 read zero
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            nxt_rdata = 8'h00;
            if (sel_sph) begin
                nxt_rdata = sp_ff[15:8];
            end
            if (sel_spl) begin
                nxt_rdata = sp_ff[7:0];
            end
            if (sel_key) begin
                nxt_rdata = key_value;
            end
            if (sel_mode) begin
                nxt_rdata = {b7_ff, 2'h0, lvl_ff, fie_ff, gie_ff};
            end
        end
    end

    // Read data register
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= 8'h00;
        end else if (clk_en) begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata = rdata_ff;
endmodule : stack_stop_sysmode_regs

// file: tb/sysctl_asserts.sv
// Checker for the system control register bank
`timescale 1ns/1ps
module sysctl_chk (
    input wire logic        sys_clk,        // Core clock
    input wire logic        reset,          // Async reset, active high
    input wire logic        clk_en,         // Clock enable
    input wire logic        reg_mode,       // Register addressing
    input wire logic        reg_wr,         // Write strobe
    input wire logic        reg_rd,         // Read strobe
    input wire logic [7:0]  reg_addr,       // Offset
    input wire logic [7:0]  reg_wdata,      // Write data
    input wire logic [7:0]  reg_rdata,      // Read data
    input wire logic        reg_hit,        // Bank hit
    input wire logic        sp_load,        // Pointer load
    input wire logic [15:0] sp_load_val,    // Pointer load value
    input wire logic        ei_exec,        // Gate open instruction
    input wire logic        di_exec,        // Gate close instruction
    input wire logic        stop_exec,      // Stop instruction
    input wire logic [15:0] stack_pointer,  // Full pointer
    input wire logic        stop_enter,     // Stop granted
    input wire logic        stop_reset,     // Bad stop reset
    input wire logic        global_int_en,  // Interrupt gate
    input wire logic        fast_int_en,    // Fast enable
    input wire logic [2:0]  fast_level,     // Fast level
    input wire logic [7:0]  fast_level_sel  // One-hot level
);
    logic [7:0] key_ff;
    logic [7:0] nxt_key;
    logic       wr_ok;
    // Shadow of the stop-guard key, needed to judge stop requests
    assign wr_ok = reg_wr && reg_mode && clk_en;
    always_comb begin
        nxt_key = key_ff;
        if (wr_ok && reg_addr == sysctl_pkg::OFF_STOP_GUARD_KEY) begin
            nxt_key = reg_wdata;
        end
    end
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            key_ff <= 8'h00;
        end else begin
            key_ff <= nxt_key;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    hit_mode_a: assert property (!reg_mode |-> !reg_hit)
        else $error("bank hit without register addressing");
    rd_unmap_a: assert property (reg_rd && clk_en && !reg_hit
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    sp_high_a: assert property (wr_ok && reg_addr == 8'hd8
        |=> stack_pointer[15:8] == $past(reg_wdata)) else $error("high byte");
    sp_low_a: assert property (wr_ok && reg_addr == 8'hd9
        |=> stack_pointer[7:0] == $past(reg_wdata)) else $error("low byte");
    stop_ok_a: assert property (stop_exec && clk_en && key_ff == 8'ha5
        |=> stop_enter && !stop_reset) else $error("stop not granted");
    stop_bad_a: assert property (stop_exec && clk_en && key_ff != 8'ha5
        |=> (stop_reset && !stop_enter) [*4] ##1 !stop_reset)
        else $error("bad stop reset length wrong");
    mode_wr_a: assert property (wr_ok && reg_addr == 8'hde
        |=> fast_int_en == $past(reg_wdata[1])
            && fast_level == $past(reg_wdata[4:2])) else $error("mode write");
    sel_hot_a: assert property (fast_level_sel ==
        (fast_int_en ? 8'h01 << fast_level : 8'h00)) else $error("fast sel");
    gie_on_a: assert property (ei_exec && clk_en |=> global_int_en)
        else $error("gate not opened");
    gie_off_a: assert property (di_exec && !ei_exec && clk_en && !wr_ok
        |=> !global_int_en) else $error("gate not closed");
    stop_ok_c: cover property (stop_enter);
    stop_bad_c: cover property (stop_reset);
    fast_c: cover property (fast_level_sel == 8'h80);
endmodule : sysctl_chk
bind stack_stop_sysmode_regs sysctl_chk u_chk (
    .sys_clk        (sys_clk),
    .reset          (reset),
    .clk_en         (clk_en),
    .reg_mode       (reg_mode),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_rdata      (reg_rdata),
    .reg_hit        (reg_hit),
    .sp_load        (sp_load),
    .sp_load_val    (sp_load_val),
    .ei_exec        (ei_exec),
    .di_exec        (di_exec),
    .stop_exec      (stop_exec),
    .stack_pointer  (stack_pointer),
    .stop_enter     (stop_enter),
    .stop_reset     (stop_reset),
    .global_int_en  (global_int_en),
    .fast_int_en    (fast_int_en),
    .fast_level     (fast_level),
    .fast_level_sel (fast_level_sel)
);

// file: tb/stack_stop_sysmode_regs_bench.sv
// Self-checking testbench for the system control register bank
`timescale 1ns/1ps
module stack_stop_sysmode_regs_bench;
    logic        sys_clk = 1'h0, reset = 1'h1, clk_en = 1'h1, reg_mode = 1'h1;
    logic        reg_wr = 1'h0, reg_rd = 1'h0, sp_load = 1'h0;
    logic        ei_exec = 1'h0, di_exec = 1'h0, stop_exec = 1'h0;
    logic        reg_hit, stop_enter, stop_reset, global_int_en, fast_int_en;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, fast_level_sel;
    logic [15:0] sp_load_val = 16'h0000, stack_pointer;
    logic [2:0]  fast_level;
    int          fail_count = 0, checked = 0;
    stack_stop_sysmode_regs u_dut (
        .sys_clk        (sys_clk),
        .reset          (reset),
        .clk_en         (clk_en),
        .reg_mode       (reg_mode),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_rdata      (reg_rdata),
        .reg_hit        (reg_hit),
        .sp_load        (sp_load),
        .sp_load_val    (sp_load_val),
        .ei_exec        (ei_exec),
        .di_exec        (di_exec),
        .stop_exec      (stop_exec),
        .stack_pointer  (stack_pointer),
        .stop_enter     (stop_enter),
        .stop_reset     (stop_reset),
        .global_int_en  (global_int_en),
        .fast_int_en    (fast_int_en),
        .fast_level     (fast_level),
        .fast_level_sel (fast_level_sel)
    );
    always #2 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] seen, exp, input string what);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, d);
        @(negedge sys_clk);
        reg_wr = 1'h1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, exp);
        @(negedge sys_clk);
        reg_rd = 1'h1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'h0;
        chk({8'h00, reg_rdata}, {8'h00, exp}, "rdata");
    endtask : rd
    task automatic ins(input logic e, d, s);
        @(negedge sys_clk);
        ei_exec = e;
        di_exec = d;
        stop_exec = s;
        @(negedge sys_clk);
        {ei_exec, di_exec, stop_exec} = 3'h0;
    endtask : ins
    task automatic stop_try(input int n_rst, n_ent);
        int r;
        int e;
        r = 0;
        e = 0;
        ins(1'h0, 1'h0, 1'h1);
        repeat (8) begin
            r += stop_reset;
            e += stop_enter;
            @(negedge sys_clk);
        end
        chk(16'(r), 16'(n_rst), "reset cycles");
        chk(16'(e), 16'(n_ent), "stop grants");
    endtask : stop_try
    task automatic t_regs;
        wr(8'hd8, 8'h12);
        wr(8'hd9, 8'h34);
        rd(8'hd8, 8'h12);
        rd(8'hd9, 8'h34);
        chk(stack_pointer, 16'h1234, "sp");
        rd(8'hde, 8'h00);
        rd(8'hfb, 8'h00);
        wr(8'hde, 8'hff);
        rd(8'hde, 8'h9f);
        for (int lv = 0; lv < 8; lv++) begin
            wr(8'hde, {3'h0, lv[2:0], 2'h2});
            chk({8'h00, fast_level_sel}, 16'h0001 << lv, "sel");
            chk({13'h0000, fast_level}, 16'(lv), "level");
        end
        wr(8'hde, 8'h1c);
        chk({8'h00, fast_level_sel}, 16'h0000, "sel off");
        chk({15'h0000, fast_int_en}, 16'h0000, "fast off");
    endtask : t_regs
    task automatic t_refuse;
        reg_mode = 1'h0;
        wr(8'hd8, 8'h55);
        chk({15'h0000, reg_hit}, 16'h0000, "hit off");
        rd(8'hd9, 8'h00);
        reg_mode = 1'h1;
        rd(8'hd8, 8'h12);
        chk({15'h0000, reg_hit}, 16'h0001, "hit on");
        rd(8'h10, 8'h00);
        chk({15'h0000, reg_hit}, 16'h0000, "hit none");
    endtask : t_refuse
    // Clock enable low: neither a write nor an instruction is taken
    task automatic t_freeze;
        @(negedge sys_clk);
        clk_en = 1'h0;
        wr(8'hd8, 8'h77);
        ins(1'h1, 1'h0, 1'h0);
        chk(stack_pointer, 16'h1234, "frozen sp");
        chk({15'h0000, global_int_en}, 16'h0000, "frozen gate");
        clk_en = 1'h1;
        rd(8'hd8, 8'h12);
    endtask : t_freeze
    task automatic t_gate;
        ins(1'h1, 1'h0, 1'h0);
        chk({15'h0000, global_int_en}, 16'h0001, "ei");
        ins(1'h0, 1'h1, 1'h0);
        chk({15'h0000, global_int_en}, 16'h0000, "di");
        ins(1'h1, 1'h1, 1'h0);
        chk({15'h0000, global_int_en}, 16'h0001, "ei and di");
    endtask : t_gate
    task automatic t_stop;
        stop_try(4, 0);
        wr(8'hfb, 8'ha5);
        stop_try(0, 1);
        wr(8'hfb, 8'h5a);
        stop_try(4, 0);
    endtask : t_stop
    task automatic t_rerun;
        @(negedge sys_clk);
        sp_load = 1'h1;
        sp_load_val = 16'hbeef;
        @(negedge sys_clk);
        sp_load = 1'h0;
        reset = 1'h1;
        @(negedge sys_clk);
        reset = 1'h0;
        chk(stack_pointer, 16'hbeef, "sp kept");
        chk({15'h0000, global_int_en}, 16'h0000, "gate");
        rd(8'hfb, 8'h00);
    endtask : t_rerun
    task automatic end_sim;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    // Main sequence
    initial begin
        repeat (8) @(negedge sys_clk);
        reset = 1'h0;
        t_regs();
        t_refuse();
        t_freeze();
        t_gate();
        t_stop();
        t_rerun();
        end_sim();
    end
    // Watchdog against a hang
    initial begin
        #20000;
        fail_count++;
        end_sim();
    end
endmodule : stack_stop_sysmode_regs_bench
